//--- shared/sram_ctrl_params.svh
/*
  Timing figures and counts for the static RAM controller.
  Assumes a 200 MHz controller clock; figures are for the 12 ns grade.
*/
`ifndef SRAM_CTRL_PARAMS_SVH
`define SRAM_CTRL_PARAMS_SVH

`define CLK_PERIOD_PS 5000
`define ADDR_ACCESS_TIME_PS 12000
`define READ_CYCLE_TIME_PS 12000
`define ADDR_SETUP_TO_WRITE_END_PS 9000
`define DATA_SETUP_TO_WRITE_END_PS 6000
`define STROBE_PULSE_WIDTH_PS 8000
`define STROBE_TO_FLOAT_DELAY_PS 6000
`define WRITE_CYCLE_TIME_PS 12000
`define OUTPUT_FLOAT_DELAY_PS 6000
`define CEIL_CYCLES(t) (((t) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define READ_WAIT_CYCLES (`CEIL_CYCLES(`ADDR_ACCESS_TIME_PS) + 1)
`define STROBE_LOW_CYCLES `CEIL_CYCLES(`STROBE_PULSE_WIDTH_PS + `STROBE_TO_FLOAT_DELAY_PS)
`define TURN_CYCLES `CEIL_CYCLES(`OUTPUT_FLOAT_DELAY_PS)

`endif

//--- shared/sram_ctrl_pkg.sv
/*
  Types for the static RAM controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sram_ctrl_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_READ = 6'h02,
    ST_WSET = 6'h04,
    ST_WLOW = 6'h08,
    ST_WEND = 6'h10,
    ST_TURN = 6'h20
  } sram_state_type;
endpackage

//--- rtl/sram_ctrl.sv
/*
  Synchronous controller for an 8K by 8 asynchronous static RAM.
  Assumes the request inputs are synchronous to ref_clk and that the bench
  resolves the data bus from data_out, data_oe and the memory's own drive.
  One access is in flight at a time and each runs its full count of cycles, which
  trades throughput for pin timing that still holds at any slower clock.
*/
// How it works
// - Data set-up and hold are timed against the terminating rising strobe edge.
// - Reads keep the strobe high while both selects and the output gate are asserted.
// - The controller never drives the bus while the memory may be driving it.
// - A strobe write with the gate low lasts at least float delay plus data set-up.
// - The address is stable no later than the start of the write overlap.
// - The address is held unchanged until the terminating edge of the write.
// - The address is valid for a minimum time before the write terminates.
// - Write data is valid for a minimum time before the terminating edge.
`timescale 1ns/100ps
`include "sram_ctrl_params.svh"

module sram_ctrl
  import sram_ctrl_pkg::*;
#(
  parameter int ADDR_W = 13,
  parameter int DATA_W = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic rsp_valid,
  output logic [ADDR_W-1:0] mem_addr,
  output logic select_low_active_n,
  output logic select_high_active,
  output logic write_strobe_n,
  output logic output_gate_n,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe
);

  // ------------------------------------------------------------
  // Cycle counts
  // ------------------------------------------------------------
  // Counts are rounded up, so the clock period can only lengthen an interval.
  localparam logic [3:0] READ_WAIT = 4'(`READ_WAIT_CYCLES);
  localparam logic [3:0] STROBE_LOW = 4'(`STROBE_LOW_CYCLES);
  localparam logic [3:0] TURN_WAIT = 4'(`TURN_CYCLES);

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  sram_state_type state_r, state_nxt;
  logic [3:0] count_r, count_nxt;
  logic req_ready_r, req_ready_nxt;
  logic rsp_valid_r, rsp_valid_nxt;
  logic [DATA_W-1:0] rsp_rdata_r, rsp_rdata_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic sel_r, sel_nxt;
  logic sel_low_n_r, sel_low_n_nxt;
  logic strobe_n_r, strobe_n_nxt;
  logic gate_n_r, gate_n_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  logic oe_r, oe_nxt;

  // ------------------------------------------------------------
  // Next values
  // ------------------------------------------------------------
  // Pins keep their value unless a state moves them, so nothing toggles mid-access.
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    req_ready_nxt = req_ready_r;
    rsp_valid_nxt = 1'b0;
    rsp_rdata_nxt = rsp_rdata_r;
    addr_nxt = addr_r;
    sel_nxt = sel_r;
    sel_low_n_nxt = sel_low_n_r;
    strobe_n_nxt = strobe_n_r;
    gate_n_nxt = gate_n_r;
    dout_nxt = dout_r;
    oe_nxt = oe_r;
    case (state_r)
      ST_IDLE: begin
        if (req_valid && req_ready_r) begin
          req_ready_nxt = 1'b0;
          addr_nxt = req_addr;
          sel_nxt = 1'b1;
          sel_low_n_nxt = 1'b0;
          if (req_write) begin
            // Gate stays high so the memory never drives during a write.
            dout_nxt = req_wdata;
            gate_n_nxt = 1'b1;
            state_nxt = ST_WSET;
          end else begin
            gate_n_nxt = 1'b0;
            count_nxt = READ_WAIT;
            state_nxt = ST_READ;
          end
        end
      end
      ST_READ: begin
        // One spare cycle covers the input register after the access time.
        if (count_r == 4'h1) begin
          rsp_rdata_nxt = data_in;
          rsp_valid_nxt = 1'b1;
          // Selects drop with the gate, so the memory floats before the turnaround.
          sel_nxt = 1'b0;
          sel_low_n_nxt = 1'b1;
          gate_n_nxt = 1'b1;
          count_nxt = TURN_WAIT;
          state_nxt = ST_TURN;
        end else begin
          count_nxt = count_r - 4'h1;
        end
      end
      ST_WSET: begin
        // Address and data settle a full cycle before the strobe falls.
        // The gate has been high for a cycle already, so driving now cannot collide.
        oe_nxt = 1'b1;
        strobe_n_nxt = 1'b0;
        count_nxt = STROBE_LOW;
        state_nxt = ST_WLOW;
      end
      ST_WLOW: begin
        // Strobe low long enough for float delay, pulse width, set-up.
        if (count_r == 4'h1) begin
          strobe_n_nxt = 1'b1;
          state_nxt = ST_WEND;
        end else begin
          count_nxt = count_r - 4'h1;
        end
      end
      ST_WEND: begin
        // Address, data and select change only after the strobe has risen.
        sel_nxt = 1'b0;
        sel_low_n_nxt = 1'b1;
        oe_nxt = 1'b0;
        count_nxt = TURN_WAIT;
        state_nxt = ST_TURN;
      end
      ST_TURN: begin
        // Deselected gap lets the memory's drivers float before reuse.
        if (count_r == 4'h1) begin
          req_ready_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end else begin
          count_nxt = count_r - 4'h1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        req_ready_nxt = 1'b1;
        sel_nxt = 1'b0;
        sel_low_n_nxt = 1'b1;
        strobe_n_nxt = 1'b1;
        gate_n_nxt = 1'b1;
        oe_nxt = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Every pin leaves a flip-flop so the strobe cannot glitch.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_IDLE;
      count_r <= 4'h0;
      req_ready_r <= 1'b1;
      rsp_valid_r <= 1'b0;
      rsp_rdata_r <= '0;
      addr_r <= '0;
      sel_r <= 1'b0;
      sel_low_n_r <= 1'b1;
      strobe_n_r <= 1'b1;
      gate_n_r <= 1'b1;
      dout_r <= '0;
      oe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      req_ready_r <= req_ready_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_rdata_r <= rsp_rdata_nxt;
      addr_r <= addr_nxt;
      sel_r <= sel_nxt;
      sel_low_n_r <= sel_low_n_nxt;
      strobe_n_r <= strobe_n_nxt;
      gate_n_r <= gate_n_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Each select has its own flop; an inverter between flop and pin could glitch.
  assign req_ready = req_ready_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_rdata = rsp_rdata_r;
  assign mem_addr = addr_r;
  assign select_low_active_n = sel_low_n_r;
  assign select_high_active = sel_r;
  assign write_strobe_n = strobe_n_r;
  assign output_gate_n = gate_n_r;
  assign data_out = dout_r;
  assign data_oe = oe_r;

endmodule

//--- sim/sram_ctrl_chk.sv
/* Pin assertions for sram_ctrl.
   Assumes the default widths of sram_ctrl. */
`timescale 1ns/100ps
module sram_ctrl_chk (
  input logic ref_clk,
  input logic reset,
  input logic req_valid,
  input logic req_write,
  input logic req_ready,
  input logic [7:0] rsp_rdata,
  input logic rsp_valid,
  input logic [12:0] mem_addr,
  input logic select_low_active_n,
  input logic select_high_active,
  input logic write_strobe_n,
  input logic output_gate_n,
  input logic [7:0] data_in,
  input logic [7:0] data_out,
  input logic data_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_rd; !output_gate_n |-> write_strobe_n; endproperty
  a_rd: assert property (p_rd) else $error("strobe low in read");
  property p_fight; data_oe |-> output_gate_n; endproperty
  a_fight: assert property (p_fight) else $error("bus fight");
  property p_wen;
    !write_strobe_n |-> !select_low_active_n && select_high_active && data_oe;
  endproperty
  a_wen: assert property (p_wen) else $error("write unqualified");
  property p_wset; $fell(write_strobe_n) |-> $stable(mem_addr) && $stable(data_out); endproperty
  a_wset: assert property (p_wset) else $error("addr moved at write start");
  property p_wend;
    $rose(write_strobe_n) |-> $stable(mem_addr) && $stable(data_out) && !select_low_active_n;
  endproperty
  a_wend: assert property (p_wend) else $error("pins moved at write end");
  property p_wlen; $fell(write_strobe_n) |-> !write_strobe_n [*3] ##1 write_strobe_n; endproperty
  a_wlen: assert property (p_wlen) else $error("strobe width");
  property p_rtime; $fell(output_gate_n) |-> ##4 rsp_valid; endproperty
  a_rtime: assert property (p_rtime) else $error("read answer late");
  property p_rdat; rsp_valid |-> rsp_rdata == $past(data_in); endproperty
  a_rdat: assert property (p_rdat) else $error("read data");
  property p_busy;
    req_valid && req_ready && !req_write |=> !req_ready [*6] ##1 req_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("read busy span");
  property p_busy_wr;
    req_valid && req_ready && req_write |=> !req_ready [*7] ##1 req_ready;
  endproperty
  a_busy_wr: assert property (p_busy_wr) else $error("write busy span");
endmodule
bind sram_ctrl sram_ctrl_chk chk (.*);

//--- sim/sram_model.sv
/* Static RAM model and data bus resolution.
   Assumes it sits on the controller pins; a floating bus toggles. */
`timescale 1ns/100ps
module sram_model (
  input logic ref_clk,
  input logic [12:0] mem_addr,
  input logic select_low_active_n,
  input logic select_high_active,
  input logic write_strobe_n,
  input logic output_gate_n,
  input logic [7:0] data_out,
  input logic data_oe,
  output logic [7:0] data_in
);
  logic [7:0] mem [8192];
  logic [7:0] last_r = 8'h00;
  wire [7:0] rd;
  wire sel = !select_low_active_n && select_high_active;
  wire drv = sel && !output_gate_n && write_strobe_n;
  // The slow path keeps old data after an address change, as the real part does.
  assign #12 rd = mem[mem_addr];
  always @* if (sel && !write_strobe_n) mem[mem_addr] = data_in;
  assign data_in = data_oe ? data_out : drv ? rd : ~last_r;
  always @(posedge ref_clk) last_r <= data_in;
endmodule

//--- sim/sram_ctrl_tb_top.sv
/* Self-checking bench for sram_ctrl.
   Assumes sram_model and the checker are compiled with it. */
`timescale 1ns/100ps
module sram_ctrl_tb_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [12:0] req_addr = 13'h0000;
  logic [7:0] req_wdata = 8'h00;
  logic req_ready, rsp_valid, select_low_active_n, select_high_active;
  logic write_strobe_n, output_gate_n, data_oe;
  logic [7:0] rsp_rdata, data_in, data_out, shadow [8192], exp_q [$];
  logic [12:0] mem_addr, addrs [16];
  int errors = 0;
  int check_count = 0;
  int seed = 44070;
  sram_ctrl uut (.*);
  sram_model mem_model (.*);
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t level %b expected %b", $time, got, exp);
    end
  endtask
  task automatic access(input logic wr, input logic [12:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    while (req_ready !== 1'b1) @(negedge ref_clk);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    if (wr) shadow[a] = d;
    else exp_q.push_back(shadow[a]);
    @(negedge ref_clk);
    req_valid = 1'b0;
  endtask
  task automatic finish_test();
    $display("Counts: checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----
  // Response watcher
  // ----
  always @(negedge ref_clk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) check1(1'b1, 1'b0);
      else check8(rsp_rdata, exp_q.pop_front());
    end
  end
  initial forever #2.5 ref_clk = ~ref_clk;
  initial begin
    #100000;
    errors++;
    finish_test();
  end
  initial begin
    logic [31:0] r;
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      addrs[i] = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1FFF : r[12:0];
      access(1'b1, addrs[i], r[20:13]);
    end
    for (int i = 0; i < 16; i++) access(1'b0, addrs[i], 8'h00);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      access(1'b1, addrs[i], r[7:0]);
      access(1'b0, addrs[i], 8'h00);
    end
    access(1'b0, addrs[2], 8'h00);
    @(negedge ref_clk);
    check1(output_gate_n, 1'b0);
    reset = 1'b1;
    void'(exp_q.pop_front());
    @(negedge ref_clk);
    check1(select_low_active_n & !select_high_active, 1'b1);
    check1(write_strobe_n & output_gate_n & !data_oe, 1'b1);
    check1(req_ready & !rsp_valid, 1'b1);
    reset = 1'b0;
    access(1'b0, addrs[1], 8'h00);
    repeat (10) @(negedge ref_clk);
    check1(exp_q.size() == 0, 1'b1);
    finish_test();
  end
endmodule
